/* File: rtl/standby_halt_control_defines.vh */
// constants for the standby and halt controller
`ifndef STANDBY_HALT_CONTROL_DEFINES_VH
`define STANDBY_HALT_CONTROL_DEFINES_VH
`define HALT_OPCODE        8'h01
`define RESET_VECTOR       12'h000
`define CLK_PERIOD_NS      50
`define OSC_SETTLE_US      10
`define OSC_SETTLE_CYCLES  ((`OSC_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_STAGES      2
`endif

/* File: rtl/pin_level_filter.v */
// two-stage level qualifier for a control pin
`timescale 1ns/100ps
`default_nettype none
module pin_level_filter #(
    parameter STAGES = 2
) (
    input  wire clk,
    input  wire rst,
    input  wire pin_in,
    output reg  level_out
);
    reg [STAGES-1:0] hist_reg;
    always @(posedge clk) begin
        if (rst) begin
            hist_reg  <= {STAGES{1'b1}};
            level_out <= 1'b1;
        end else begin
            hist_reg <= {hist_reg[STAGES-2:0], pin_in};
            // change only when all samples agree
            if (&hist_reg)
                level_out <= 1'b1;
            else if (~|hist_reg)
                level_out <= 1'b0;
        end
    end
endmodule // pin_level_filter
`default_nettype wire

/* File: rtl/settle_timer.v */
// oscillator settle counter
`timescale 1ns/100ps
`default_nettype none
module settle_timer #(
    parameter WIDTH = 16,
    parameter COUNT = 200
) (
    input  wire clk,
    input  wire rst,
    input  wire start,
    output wire done
);
    reg [WIDTH-1:0] cnt_reg;
    always @(posedge clk) begin
        if (rst)
            cnt_reg <= {WIDTH{1'b0}};
        else if (start)
            cnt_reg <= COUNT[WIDTH-1:0];
        else if (cnt_reg != {WIDTH{1'b0}})
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
    assign done = (cnt_reg == {WIDTH{1'b0}}) & ~start;
endmodule // settle_timer
`default_nettype wire

/* File: rtl/standby_halt_control.v */
// standby, power-down and halt sequencing for the processor core
`timescale 1ns/100ps
`default_nettype none
`include "standby_halt_control_defines.vh"
// Functional notes
// - reset low then power-save low stops oscillator, RAM kept.
// - power-save high then reset high restarts from full reset at 0.
// - single-step low then power-save low stops oscillator, all state kept.
// - power-save high then single-step high resumes from held state.
// - opcode 01 decodes as the halt instruction.
// - halt mode begins right after the halt instruction completes.
// - halt keeps oscillator running, freezes internal clocks and state.
// - only reset or external interrupt low ends halt mode.
// - reset ending halt performs ordinary reset, start at 000.
// - interrupt release with interrupts enabled: one instruction, then service.
// - interrupt release with interrupts disabled: resume after halt, no service.
// - power-down: data bus, ports, test-0 float with inputs disabled; test-1 off.
// - oscillator stopped: reset, single-step, interrupt, access inputs off; pull-ups off.
// - power-down: read, write, latch, expander, program strobes float.
// - halt keeps data bus and port values.
// - halt keeps test-0 pin status.
// - power-save is active low and requests power saving.
// - single-step low gives wait state (CORE_WAIT) three clocks later through the pin filter, without waiting for INSTR_DONE.
module standby_halt_control #(
    parameter SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
    parameter SETTLE_WIDTH  = 16
) (
    input  wire        REF_CLK,
    input  wire        RESET,
    input  wire        POWER_SAVE_N,
    input  wire        RESET_PIN_N,
    input  wire        SINGLE_STEP_N,
    input  wire        INTERRUPT_N,
    input  wire        INTERRUPTS_ENABLED_STATE,
    input  wire [7:0]  OPCODE,
    input  wire        INSTR_DONE,
    output wire        OSC_RUN,
    output wire        CORE_CLK_EN,
    output wire        CORE_RESET,
    output wire        CORE_WAIT,
    output reg         HALTED,
    output reg         POWER_DOWN_RAM,
    output reg         POWER_DOWN_ALL,
    output wire        IRQ_SERVICE_ALLOW,
    output wire        PIN_FLOAT,
    output wire        PIN_INPUT_DISABLE,
    output wire        TEST_ONE_DISABLE,
    output wire        CTRL_INPUT_DISABLE,
    output wire        PULLUP_ENABLE,
    output wire        STROBE_FLOAT,
    output wire        HALT_STROBE_IDLE,
    output wire        HOLD_PIN_STATE,
    output wire [11:0] RESTART_VECTOR
);
    localparam [5:0] ST_RUN    = 6'h01;
    localparam [5:0] ST_HALT   = 6'h02;
    localparam [5:0] ST_PD_RAM = 6'h04;
    localparam [5:0] ST_PD_ALL = 6'h08;
    localparam [5:0] ST_SETTLE = 6'h10;
    localparam [5:0] ST_STEP   = 6'h20;

    reg  [5:0] state_reg;
    reg  [5:0] state_next;
    reg        kind_all_reg;
    reg        kind_all_next;
    reg        one_more_reg;
    reg        one_more_next;
    reg        settle_start;
    wire       ps_n;
    wire       rst_n;
    wire       ss_n;
    wire       int_n;
    wire       settle_done;
    wire       is_halt_op;

    pin_level_filter #(.STAGES(`FILTER_STAGES)) ps_filter (
        .clk       (REF_CLK),
        .rst       (RESET),
        .pin_in    (POWER_SAVE_N),
        .level_out (ps_n)
    );
    pin_level_filter #(.STAGES(`FILTER_STAGES)) rst_filter (
        .clk       (REF_CLK),
        .rst       (RESET),
        .pin_in    (RESET_PIN_N),
        .level_out (rst_n)
    );
    pin_level_filter #(.STAGES(`FILTER_STAGES)) ss_filter (
        .clk       (REF_CLK),
        .rst       (RESET),
        .pin_in    (SINGLE_STEP_N),
        .level_out (ss_n)
    );
    pin_level_filter #(.STAGES(`FILTER_STAGES)) int_filter (
        .clk       (REF_CLK),
        .rst       (RESET),
        .pin_in    (INTERRUPT_N),
        .level_out (int_n)
    );

    settle_timer #(.WIDTH(SETTLE_WIDTH), .COUNT(SETTLE_CYCLES)) osc_settle (
        .clk   (REF_CLK),
        .rst   (RESET),
        .start (settle_start),
        .done  (settle_done)
    );

    assign is_halt_op = (OPCODE == `HALT_OPCODE);

    always @* begin
        state_next    = state_reg;
        kind_all_next = kind_all_reg;
        one_more_next = one_more_reg;
        settle_start  = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (!ps_n && !rst_n) begin
                    state_next    = ST_PD_RAM;
                    kind_all_next = 1'b0;
                end else if (!ps_n && !ss_n) begin
                    state_next    = ST_PD_ALL;
                    kind_all_next = 1'b1;
                end else if (INSTR_DONE && is_halt_op && rst_n) begin
                    state_next = ST_HALT;
                end else if (INSTR_DONE && one_more_reg) begin
                    one_more_next = 1'b0;
                end
            end
            ST_HALT: begin
                if (!rst_n) begin
                    state_next    = ST_RUN;
                    one_more_next = 1'b0;
                end else if (!int_n) begin
                    state_next    = ST_RUN;
                    one_more_next = INTERRUPTS_ENABLED_STATE;
                end
            end
            ST_PD_RAM, ST_PD_ALL: begin
                if (ps_n) begin
                    state_next   = ST_SETTLE;
                    settle_start = 1'b1;
                end
            end
            ST_SETTLE: begin
                if (!ps_n) begin
                    state_next = kind_all_reg ? ST_PD_ALL : ST_PD_RAM;
                end else if (settle_done) begin
                    state_next = ST_STEP;
                end
            end
            ST_STEP: begin
                if (!ps_n) begin
                    state_next = kind_all_reg ? ST_PD_ALL : ST_PD_RAM;
                end else if (kind_all_reg ? ss_n : rst_n) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            state_reg      <= ST_RUN;
            kind_all_reg   <= 1'b0;
            one_more_reg   <= 1'b0;
            HALTED         <= 1'b0;
            POWER_DOWN_RAM <= 1'b0;
            POWER_DOWN_ALL <= 1'b0;
        end else begin
            state_reg      <= state_next;
            kind_all_reg   <= kind_all_next;
            one_more_reg   <= one_more_next;
            HALTED         <= (state_next == ST_HALT);
            POWER_DOWN_RAM <= (state_next == ST_PD_RAM);
            POWER_DOWN_ALL <= (state_next == ST_PD_ALL);
        end
    end

    wire in_pd   = (state_reg == ST_PD_RAM) | (state_reg == ST_PD_ALL);
    wire in_wake = (state_reg == ST_SETTLE) | (state_reg == ST_STEP);
    wire in_halt = (state_reg == ST_HALT);

    assign OSC_RUN            = ~in_pd;
    assign CORE_CLK_EN        = (state_reg == ST_RUN) & ss_n;
    assign CORE_RESET         = ~rst_n & (state_reg != ST_PD_ALL);
    assign CORE_WAIT          = ~ss_n & (state_reg == ST_RUN);
    assign IRQ_SERVICE_ALLOW  = (state_reg == ST_RUN) & ~one_more_reg;
    assign PIN_FLOAT          = in_pd | in_wake;
    assign PIN_INPUT_DISABLE  = in_pd | in_wake;
    assign TEST_ONE_DISABLE   = in_pd | in_wake | in_halt;
    assign CTRL_INPUT_DISABLE = in_pd;
    assign PULLUP_ENABLE      = ~in_pd;
    assign STROBE_FLOAT       = in_pd | in_wake;
    assign HALT_STROBE_IDLE   = in_halt;
    assign HOLD_PIN_STATE     = in_halt;
    assign RESTART_VECTOR     = `RESET_VECTOR;
endmodule // standby_halt_control
`default_nettype wire

/* File: tb/standby_halt_control_sva.sv */
// assertion checker for the standby and halt controller
`timescale 1ns/100ps
`default_nettype none
module standby_halt_control_sva (
    input wire        REF_CLK,
    input wire        RESET,
    input wire        RESET_PIN_N,
    input wire        INTERRUPT_N,
    input wire        INSTR_DONE,
    input wire [7:0]  OPCODE,
    input wire        OSC_RUN,
    input wire        CORE_CLK_EN,
    input wire        CORE_RESET,
    input wire        HALTED,
    input wire        POWER_DOWN_RAM,
    input wire        POWER_DOWN_ALL,
    input wire        PIN_FLOAT,
    input wire        PIN_INPUT_DISABLE,
    input wire        TEST_ONE_DISABLE,
    input wire        CTRL_INPUT_DISABLE,
    input wire        PULLUP_ENABLE,
    input wire        STROBE_FLOAT,
    input wire        HALT_STROBE_IDLE,
    input wire        HOLD_PIN_STATE,
    input wire [11:0] RESTART_VECTOR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence pins_quiet;
        (INTERRUPT_N && RESET_PIN_N) [*4];
    endsequence
    sequence int_held;
        HALTED && $fell(INTERRUPT_N) ##1 !INTERRUPT_N [*3];
    endsequence
    halt_entry_a: assert property (INSTR_DONE && OPCODE == 8'h01 && CORE_CLK_EN && !CORE_RESET
        |=> HALTED) else $error("halt opcode ignored");
    halt_freeze_a: assert property (HALTED |-> !CORE_CLK_EN && OSC_RUN)
        else $error("clocks run in halt");
    halt_hold_a: assert property (pins_quiet ##0 HALTED |=> HALTED)
        else $error("halt left without cause");
    int_release_a: assert property (int_held |-> ##[0:1] !HALTED)
        else $error("interrupt did not end halt");
    halt_pins_a: assert property (HALTED |-> HOLD_PIN_STATE && HALT_STROBE_IDLE && TEST_ONE_DISABLE)
        else $error("halt pin state wrong");
    pd_float_a: assert property (POWER_DOWN_RAM || POWER_DOWN_ALL |-> PIN_FLOAT && STROBE_FLOAT
        && PIN_INPUT_DISABLE && TEST_ONE_DISABLE && !OSC_RUN)
        else $error("power-down pins wrong");
    osc_stop_a: assert property (!OSC_RUN |-> CTRL_INPUT_DISABLE && !PULLUP_ENABLE)
        else $error("inputs live while stopped");
    vector_zero_a: assert property (RESTART_VECTOR == 12'h000)
        else $error("restart vector not zero");
    all_keep_a: assert property (POWER_DOWN_ALL |-> !CORE_RESET)
        else $error("state lost in full retention");
endmodule // standby_halt_control_sva
bind standby_halt_control standby_halt_control_sva u_sva (.*);
`default_nettype wire

/* File: tb/power_supervisor.sv */
// external supervisor driving power-save, reset and single-step
`timescale 1ns/100ps
`default_nettype none
module power_supervisor (
    input  wire logic ref_clk,
    output var logic  power_save_n,
    output var logic  reset_pin_n,
    output var logic  single_step_n
);
    initial begin
        power_save_n = 1'b1;
        reset_pin_n = 1'b1;
        single_step_n = 1'b1;
    end
    task set_reset(input logic v);
        reset_pin_n = v;
    endtask
    task set_step(input logic v);
        single_step_n = v;
    endtask
    task enter_mode(input int all);
        if (all != 0) single_step_n = 1'b0;
        else reset_pin_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        power_save_n = 1'b0;
    endtask
    task leave_mode(input int all, input int wait_cycles);
        power_save_n = 1'b1;
        repeat (wait_cycles) @(posedge ref_clk);
        #1;
        if (all != 0) single_step_n = 1'b1;
        else reset_pin_n = 1'b1;
    endtask
endmodule // power_supervisor
`default_nettype wire

/* File: tb/test_standby_halt_control.sv */
// self-checking bench for the standby and halt controller
`timescale 1ns/100ps
`default_nettype none
module test_standby_halt_control;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic INTERRUPT_N = 1'b1;
    logic IEN = 1'b1;
    logic [7:0] OPCODE = 8'h00;
    logic INSTR_DONE = 1'b0;
    wire PS_N, RST_N, SS_N, OSC_RUN, CORE_CLK_EN, CORE_RESET, HALTED, PD_RAM, PD_ALL, IRQ_OK;
    wire PIN_FLOAT, STROBE_FLOAT, CTRL_DIS, PULLUP, HOLD, STEP_WAIT;
    wire [11:0] VEC;
    int n_errors = 0;
    int check_count = 0;
    int model_state = 0;
    always #25 REF_CLK = ~REF_CLK;
    power_supervisor u_power_supervisor (.ref_clk(REF_CLK), .power_save_n(PS_N),
        .reset_pin_n(RST_N), .single_step_n(SS_N));
    standby_halt_control #(.SETTLE_CYCLES(4)) u_standby_halt_control (.REF_CLK(REF_CLK),
        .RESET(RESET), .POWER_SAVE_N(PS_N), .RESET_PIN_N(RST_N), .SINGLE_STEP_N(SS_N),
        .INTERRUPT_N(INTERRUPT_N), .INTERRUPTS_ENABLED_STATE(IEN), .OPCODE(OPCODE),
        .INSTR_DONE(INSTR_DONE), .OSC_RUN(OSC_RUN), .CORE_CLK_EN(CORE_CLK_EN),
        .CORE_RESET(CORE_RESET), .CORE_WAIT(STEP_WAIT), .HALTED(HALTED), .POWER_DOWN_RAM(PD_RAM),
        .POWER_DOWN_ALL(PD_ALL), .IRQ_SERVICE_ALLOW(IRQ_OK), .PIN_FLOAT(PIN_FLOAT),
        .PIN_INPUT_DISABLE(), .TEST_ONE_DISABLE(), .CTRL_INPUT_DISABLE(CTRL_DIS),
        .PULLUP_ENABLE(PULLUP), .STROBE_FLOAT(STROBE_FLOAT), .HALT_STROBE_IDLE(),
        .HOLD_PIN_STATE(HOLD), .RESTART_VECTOR(VEC));
    task end_of_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task instr(input logic [7:0] op);
        OPCODE = op;
        INSTR_DONE = 1'b1;
        tick(1);
        INSTR_DONE = 1'b0;
        tick(1);
    endtask
    task expect_mode;
        chk({HALTED, PD_RAM, PD_ALL}, {model_state == 1, model_state == 2, model_state == 3});
    endtask
    task wait_on(input int sel);
        for (int i = 0; i < 60; i++) begin
            if (sel == 0 ? HALTED === 1'b0 : sel == 1 ? PD_RAM === 1'b1
                : sel == 2 ? PD_ALL === 1'b1 : CORE_CLK_EN === 1'b1) return;
            tick(1);
        end
        n_errors++;
        $display("[FAIL] %0t wait timed out", $time);
        end_of_test();
    endtask
    initial begin
        void'($urandom(32'h2282));
        tick(5);
        RESET = 1'b0;
        tick(4);
        for (int i = 0; i < 8; i++) begin
            instr(8'($urandom_range(2, 255)));
            expect_mode();
        end
        for (int en = 1; en >= 0; en--) begin
            IEN = en[0];
            instr(8'h01);
            model_state = 1;
            expect_mode();
            chk({CORE_CLK_EN, HOLD}, 2'b01);
            instr(8'($urandom_range(2, 255)));
            tick(6);
            expect_mode();
            INTERRUPT_N = 1'b0;
            wait_on(0);
            model_state = 0;
            INTERRUPT_N = 1'b1;
            chk(IRQ_OK, !en[0]);
            instr(8'h02);
            chk(IRQ_OK, 1'b1);
        end
        instr(8'h01);
        u_power_supervisor.set_reset(1'b0);
        wait_on(0);
        chk(CORE_RESET, 1'b1);
        chk(VEC, 12'h000);
        u_power_supervisor.set_reset(1'b1);
        tick(6);
        u_power_supervisor.set_step(1'b0);
        tick(4);
        chk({STEP_WAIT, CORE_CLK_EN}, 2'b10);
        u_power_supervisor.set_step(1'b1);
        tick(4);
        chk({STEP_WAIT, CORE_CLK_EN}, 2'b01);
        for (int m = 0; m < 2; m++) begin
            u_power_supervisor.enter_mode(m);
            wait_on(1 + m);
            model_state = 2 + m;
            expect_mode();
            chk(CORE_RESET, m == 0);
            chk({OSC_RUN, PIN_FLOAT, STROBE_FLOAT, CTRL_DIS, PULLUP}, 5'b01110);
            u_power_supervisor.leave_mode(m, 2);
            tick(4);
            chk(CORE_CLK_EN, 1'b0);
            wait_on(3);
            model_state = 0;
            expect_mode();
            chk(CORE_RESET, 1'b0);
        end
        end_of_test();
    end
endmodule // test_standby_halt_control
`default_nettype wire
